// ### design/ppsac_pkg.sv
// Purpose: shared constants and types for the parallel port strobe/location configuration block
// Assumes: 16-bit registers reached over a plain strobe port
// Notes:   offsets are word indices on the plain register port
package ppsac_pkg;

  localparam int unsigned PPSAC_DATA_W = 16;
  localparam int unsigned PPSAC_ADDR_W = 4;
  localparam int unsigned PPSAC_LOC_W  = 11;

  // register offsets
  localparam logic [3:0] PPSAC_OFS_CONTROL  = 4'h0;
  localparam logic [3:0] PPSAC_OFS_LOCATION = 4'h1;
  localparam logic [3:0] PPSAC_OFS_PIN_EN   = 4'h2;

  // control register fields; the chip select bits sit in the location and pin enable registers
  localparam int unsigned PPSAC_BIT_RD_POL   = 0;
  localparam int unsigned PPSAC_BIT_WR_POL   = 1;
  localparam int unsigned PPSAC_BIT_BE_POL   = 2;
  localparam int unsigned PPSAC_BIT_MODE_LO  = 8;
  localparam int unsigned PPSAC_BIT_CS_ACT   = 14;
  localparam int unsigned PPSAC_BIT_CS_PINEN = 14;

  // implemented bits and reset values
  localparam logic [15:0] PPSAC_CONTROL_MASK = 16'h0307;
  localparam logic [15:0] PPSAC_LOC_MASK     = 16'h47FF;
  localparam logic [15:0] PPSAC_RESET_CONTROL  = 16'h0000;
  localparam logic [15:0] PPSAC_RESET_LOCATION = 16'h0000;
  localparam logic [15:0] PPSAC_RESET_PIN_EN   = 16'h0000;
  localparam logic [10:0] PPSAC_SMALL_PKG_MASK = 11'h003;

  typedef enum logic [1:0] {
    PPSAC_SLAVE_LEGACY,
    PPSAC_SLAVE_BUFFERED,
    PPSAC_MASTER_TWO,
    PPSAC_MASTER_ONE
  } ppsac_mode_e;

  // raw strobe requests from the transfer engine, all active high
  typedef struct packed {
    logic rd;
    logic wr;
    logic be;
    logic cs;
    logic latch_hi;
    logic latch_lo;
  } ppsac_req_s;

  // pad-level outputs
  typedef struct packed {
    logic [10:0] loc;
    logic [10:0] loc_en;
    logic        read_strobe_pin;
    logic        write_strobe_pin;
    logic        byte_enable_pin;
    logic        first_chip_select_pin;
    logic        first_chip_select_en;
  } ppsac_pads_s;

endpackage : ppsac_pkg

// ### design/ppsac_regs.sv
// Purpose: register file of the strobe/location configuration block
// Assumes: one-cycle strobes, never both at once
// Notes:   read data are valid only in the cycle after the read strobe
`timescale 1ns/1ns
`default_nettype none
module ppsac_regs
  import ppsac_pkg::*;
(
  // clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_reset_n,
  // register port
  input  wire logic [PPSAC_ADDR_W-1:0] i_addr,
  input  wire logic [15:0]             i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic      [15:0]             o_rdata,
  // register contents
  output logic      [15:0]             o_control,
  output logic      [15:0]             o_location,
  output logic      [15:0]             o_pin_en
);

  ////////////////////////////////////////////////////////////////////////
  // writes; unimplemented bits never store so they read zero
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_control  <= PPSAC_RESET_CONTROL;
      o_location <= PPSAC_RESET_LOCATION;
      o_pin_en   <= PPSAC_RESET_PIN_EN;
    end
    else if (i_wr)
    begin
      if (i_addr == PPSAC_OFS_CONTROL)
        o_control <= i_wdata & PPSAC_CONTROL_MASK;
      else if (i_addr == PPSAC_OFS_LOCATION)
        o_location <= i_wdata & PPSAC_LOC_MASK;
      else if (i_addr == PPSAC_OFS_PIN_EN)
        o_pin_en <= i_wdata & PPSAC_LOC_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reads; unmapped offsets answer zero
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_rdata <= 16'h0000;
    else if (i_rd)
    begin
      if (i_addr == PPSAC_OFS_CONTROL)
        o_rdata <= o_control;
      else if (i_addr == PPSAC_OFS_LOCATION)
        o_rdata <= o_location;
      else if (i_addr == PPSAC_OFS_PIN_EN)
        o_rdata <= o_pin_en;
      else
        o_rdata <= 16'h0000;
    end
    else
      o_rdata <= 16'h0000;
  end

endmodule : ppsac_regs
`default_nettype wire

// ### design/ppsac_top.sv
// Purpose: strobe polarity, location and pin ownership for a parallel port
// Assumes: the transfer engine raises active-high strobe requests
// Notes:   every pad output is registered, so pads follow requests one cycle late
`timescale 1ns/1ns
`default_nettype none

module ppsac_top
  import ppsac_pkg::*;
#(
  parameter bit SMALL_PACKAGE = 1'b0
)
(
  // clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_reset_n,
  // register port
  input  wire logic [PPSAC_ADDR_W-1:0] i_addr,
  input  wire logic [15:0]             i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic      [15:0]             o_rdata,
  // transfer engine
  input  wire ppsac_req_s              i_req,
  input  wire logic                    i_latch_mode,
  output ppsac_mode_e                  o_mode,
  // pads
  output ppsac_pads_s                  o_pads
);

  logic [15:0]  control;
  logic [15:0]  location;
  logic [15:0]  pin_en;
  logic [10:0]  live_en;
  ppsac_mode_e  mode;
  ppsac_pads_s  next_pads;

  ////////////////////////////////////////////////////////////////////////
  // register file
  ppsac_regs u_regs (
    .i_clk      (i_clk),
    .i_reset_n  (i_reset_n),
    .i_addr     (i_addr),
    .i_wdata    (i_wdata),
    .i_wr       (i_wr),
    .i_rd       (i_rd),
    .o_rdata    (o_rdata),
    .o_control  (control),
    .o_location (location),
    .o_pin_en   (pin_en)
  );

  // apply an active level: high when pol set, low otherwise
  function automatic logic ppsac_level(input logic pol, input logic act);
    return pol ? act : ~act;
  endfunction : ppsac_level

  ////////////////////////////////////////////////////////////////////////
  // missing pads on the small package are never enabled
  always_comb
  begin
    live_en = pin_en[10:0];
    if (SMALL_PACKAGE)
      live_en = live_en & PPSAC_SMALL_PKG_MASK;
    mode = ppsac_mode_e'(control[PPSAC_BIT_MODE_LO +: 2]);
  end

  ////////////////////////////////////////////////////////////////////////
  // pad values; location pads show latch strobes or address bits
  always_comb
  begin
    next_pads        = '0;
    next_pads.loc_en = live_en;
    next_pads.loc    = location[10:0] & live_en;
    if (i_latch_mode)
    begin
      // pads 1 and 0 as latch strobes, kept high-active
      next_pads.loc[1] = live_en[1] & i_req.latch_hi;
      next_pads.loc[0] = live_en[0] & i_req.latch_lo;
    end
    // in mode 11 the read pad and the write pad both carry the combined strobe rd | wr
    case (mode)
      PPSAC_MASTER_ONE:
      begin
        next_pads.read_strobe_pin  = ppsac_level(control[PPSAC_BIT_RD_POL], i_req.rd | i_req.wr);
        next_pads.write_strobe_pin = ppsac_level(control[PPSAC_BIT_WR_POL], i_req.wr | i_req.rd);
      end
      default:
      begin
        next_pads.read_strobe_pin  = ppsac_level(control[PPSAC_BIT_RD_POL], i_req.rd);
        next_pads.write_strobe_pin = ppsac_level(control[PPSAC_BIT_WR_POL], i_req.wr);
      end
    endcase
    next_pads.byte_enable_pin = ppsac_level(control[PPSAC_BIT_BE_POL], i_req.be);
    // chip select only with both bits set unless location line 10 is enabled; pad left to port I/O while pin enable bit 14 is clear
    next_pads.first_chip_select_en  = pin_en[PPSAC_BIT_CS_PINEN];
    next_pads.first_chip_select_pin = pin_en[PPSAC_BIT_CS_PINEN]
                                      & location[PPSAC_BIT_CS_ACT] & i_req.cs;
    // a pad carrying location line 10 ignores location bit 14 and the request; its enable still follows pin enable bit 14
    if (live_en[PPSAC_LOC_W-1])
      next_pads.first_chip_select_pin = location[PPSAC_LOC_W-1];
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs so pads never glitch on decode
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_pads <= '0;
      o_mode <= PPSAC_SLAVE_LEGACY;
    end
    else
    begin
      o_pads <= next_pads;
      o_mode <= mode;
    end
  end

endmodule : ppsac_top
`default_nettype wire

// ### sim/ppsac_periph.sv
// Purpose: far-side peripheral reading the strobe pads
// Assumes: it is told the programmed active levels
// Notes:   decodes pad levels into active flags
`timescale 1ns/1ns
`default_nettype none
module ppsac_periph
  import ppsac_pkg::*;
(
  // pads and active levels, be wr rd
  input  wire ppsac_pads_s i_pads,
  input  wire logic [2:0]  i_pol,
  // active flags, be wr rd
  output logic      [2:0]  o_act
);
  // a pad at the programmed level counts as active
  assign o_act = {i_pads.byte_enable_pin, i_pads.write_strobe_pin, i_pads.read_strobe_pin} ~^ i_pol;
endmodule : ppsac_periph
`default_nettype wire

// ### sim/ppsac_top_asserts.sv
// Purpose: port-level checks for ppsac_top
// Assumes: pads follow inputs one edge late
// Notes:   shadows mirror register writes
`timescale 1ns/1ns
`default_nettype none
module ppsac_chk
  import ppsac_pkg::*;
#(
  parameter bit SMALL_PACKAGE = 1'b0
)
(
  // watched ports
  input  wire logic                    i_clk,
  input  wire logic                    i_reset_n,
  input  wire logic [PPSAC_ADDR_W-1:0] i_addr,
  input  wire logic [15:0]             i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  input  wire logic [15:0]             o_rdata,
  input  wire ppsac_req_s              i_req,
  input  wire logic                    i_latch_mode,
  input  wire ppsac_pads_s             o_pads
);
  logic [15:0] ctl, loc, pen, rb;
  logic [10:0] len, lx;
  logic [2:0]  e;
  logic        up, r, w, ecs;
  // shadows; up skips the first edge, where pads still hold reset
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
      {up, ctl, loc, pen} <= '0;
    else
    begin
      up <= 1'b1;
      if (i_wr && i_addr == 4'h0) ctl <= i_wdata;
      if (i_wr && i_addr == 4'h1) loc <= i_wdata;
      if (i_wr && i_addr == 4'h2) pen <= i_wdata;
    end
  // expected pads; mode 11 puts either request on both strobes
  assign r   = i_req.rd | (ctl[9:8] == 2'h3 && i_req.wr);
  assign w   = i_req.wr | (ctl[9:8] == 2'h3 && i_req.rd);
  assign e   = {ctl[2] ~^ i_req.be, ctl[1] ~^ w, ctl[0] ~^ r};
  assign ecs = pen[14] & loc[14] & i_req.cs;
  assign len = pen[10:0] & (SMALL_PACKAGE ? PPSAC_SMALL_PKG_MASK : 11'h7FF);
  assign lx  = {loc[10:2], i_latch_mode ? {i_req.latch_hi, i_req.latch_lo} : loc[1:0]} & len;
  assign rb  = i_addr == 4'h0 ? ctl & PPSAC_CONTROL_MASK : i_addr == 4'h1 ? loc & PPSAC_LOC_MASK :
               i_addr == 4'h2 ? pen & PPSAC_LOC_MASK : 16'h0000;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  a_read_level: assert property (up |-> o_pads.read_strobe_pin == $past(e[0]))
    else $error("read strobe level wrong");
  a_write_level: assert property (up |-> o_pads.write_strobe_pin == $past(e[1]))
    else $error("write strobe level wrong");
  a_byte_level: assert property (up |-> o_pads.byte_enable_pin == $past(e[2]))
    else $error("byte enable level wrong");
  a_select_gate: assert property (up && !$past(len[10]) |-> o_pads.first_chip_select_pin == $past(ecs)
    && o_pads.first_chip_select_en == $past(pen[14]))
    else $error("chip select wrong");
  a_pin_owner: assert property (up |-> o_pads.loc_en == $past(len))
    else $error("pad ownership wrong");
  a_loc_lines: assert property (up |-> (o_pads.loc & o_pads.loc_en) == $past(lx))
    else $error("location lines wrong");
  a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data outside read");
  a_read_back: assert property ($past(i_rd) |-> o_rdata == $past(rb))
    else $error("read data wrong");
  c_mode_one: cover property (up && ctl[9:8] == 2'h3 && i_req.rd);
  c_select: cover property (ecs && !len[10]);
  c_unmapped: cover property (i_rd && i_addr == 4'h3);
endmodule : ppsac_chk
bind ppsac_top ppsac_chk #(.SMALL_PACKAGE(SMALL_PACKAGE)) chk (.i_clk, .i_reset_n, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .i_req, .i_latch_mode, .o_pads);
`default_nettype wire

// ### sim/ppsac_top_tb.sv
// Purpose: self-checking bench for ppsac_top
// Assumes: default package size
// Notes:   model registers are plain ints
`timescale 1ns/1ns
`default_nettype none
module ppsac_top_tb
  import ppsac_pkg::*;
;
  logic        i_clk = 1'b0, i_reset_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_latch_mode = 1'b0;
  logic [3:0]  i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000, o_rdata;
  logic [31:0] seed = 32'h0000172E;
  logic [2:0]  act;
  logic        r, w;
  ppsac_req_s  i_req = '0;
  ppsac_mode_e o_mode;
  ppsac_pads_s o_pads;
  int          num_errors = 0, tests_run = 0;
  int          m[4];
  int          mk[4] = '{16'h0307, 16'h47FF, 16'h47FF, 16'h0000};
  ppsac_top DUT (.i_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_req, .i_latch_mode,
    .o_mode, .o_pads);
  ppsac_periph peer (.i_pads(o_pads), .i_pol(m[0][2:0]), .o_act(act));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one-cycle write; the model drops unmapped and unimplemented bits
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= {2'b00, a};
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    m[a] = d & mk[a];
  endtask : wr
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= {2'b00, a};
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, 16'(m[a]), "rdata");
  endtask : rd
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  initial forever #20 i_clk = ~i_clk;
  // two passes; the second starts from a mid-run reset
  initial
  begin
    for (int k = 0; k < 2; k++)
    begin
      i_reset_n <= 1'b0;
      m = '{0, 0, 0, 0};
      repeat (5) @(posedge i_clk);
      i_reset_n <= 1'b1;
      for (int a = 0; a < 4; a++) rd(2'(a));
      repeat (16)
      begin
        wr(2'(rnd()), 16'(rnd()));
        rd(2'(rnd()));
      end
      $display("register test %0d done", k);
      repeat (64)
      begin
        wr(2'h0, 16'(rnd()));
        wr(2'h1, 16'(rnd()));
        wr(2'h2, 16'(rnd()));
        @(posedge i_clk);
        i_req <= 6'(rnd());
        i_latch_mode <= 1'(rnd());
        @(posedge i_clk);
        #1;
        r = i_req.rd | (m[0][9:8] == 2'h3 && i_req.wr);
        w = i_req.wr | (m[0][9:8] == 2'h3 && i_req.rd);
        chk(16'(act), {13'h0000, i_req.be, w, r}, "strobes");
        chk(16'(o_mode), 16'(m[0][9:8]), "mode");
        chk(16'(o_pads.loc_en), 16'(m[2][10:0]), "owner");
        chk(16'(o_pads.first_chip_select_pin),
          16'(m[2][10] ? m[1][10] : m[2][14] & m[1][14] & i_req.cs), "select");
        chk(16'(o_pads.loc & o_pads.loc_en),
          16'({m[1][10:2], i_latch_mode ? {i_req.latch_hi, i_req.latch_lo} : m[1][1:0]} & m[2][10:0]), "lines");
      end
      $display("pad test %0d done", k);
    end
    complete_run();
  end
endmodule : ppsac_top_tb
`default_nettype wire
